/* shared/sbp_pkg.sv */
// Constants shared by the subchannel bit packer.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
package sbp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned FRAME_NS      = 125000;
  localparam int unsigned FRAME_CYCLES  = FRAME_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_MODE       = 8'h00;
  localparam logic [7:0] ADDR_FIFO_SEL   = 8'h04;
  localparam logic [7:0] ADDR_SUBCH_CFG  = 8'h08;
  localparam logic [7:0] ADDR_CHANNEL    = 8'h0C;
  localparam logic [7:0] ADDR_FILL_MASK  = 8'h10;
  localparam logic [7:0] ADDR_NEXT_FIFO  = 8'h14;
  localparam logic [7:0] ADDR_FIRST_FIFO = 8'h18;
  localparam logic [7:0] ADDR_STATUS     = 8'h1C;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int unsigned MODE_ARB_BIT  = 0;
  localparam int unsigned MODE_LIST_BIT = 1;
  localparam int unsigned ENTRY_W       = 6;
  localparam int unsigned CNT_LSB       = 0;
  localparam int unsigned START_LSB     = 3;
  localparam int unsigned FIELD3_W      = 3;
  localparam int unsigned CHAN_LSB      = 1;
  localparam int unsigned CHAN_W        = 5;
  localparam int unsigned TERM_BIT      = 6;
  localparam int unsigned BUSY_BIT      = 31;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [2:0] RST_BIT_COUNT = 3'h0;
  localparam logic [2:0] RST_START_BIT = 3'h0;
  localparam logic [7:0] RST_MASK      = 8'h00;

  // ****************************************************************
  // Frame walk states
  // ****************************************************************
  typedef enum logic [1:0] {
    SBP_IDLE  = 2'h0,
    SBP_WALK  = 2'h1,
    SBP_LATCH = 2'h3
  } sbp_state_e;

endpackage

/* core/sbp_core.sv */
// Subchannel bit packer between the FIFOs and the internal channels.
// Assumes each FIFO head byte is valid on i_fifo_data and advances one
// cycle after its pop pulse; channel bytes are sampled once per frame.
//
// Function
// - Extraction, insertion per FIFO, mask per channel.
// - Fewer than eight bits may move.
// - Bit count and start bit select bits.
// - Fill mask used for transmit only.
// - Each channel has its own mask.
// - Mask goes to FIFO's assigned channel.
// - Reset config moves whole bytes.
// - One byte per FIFO per frame outside list mode.
// - Configured transmit bits merge into mask.
// - Selected bits keep their bit positions.
// - Receive stores whole channel bytes.
// - Fixed mode: FIFO number is channel.
// - Arbitrary mode: FIFOs share a channel.
// - Unoccupied bits come from the mask.
// - Receive byte goes to every FIFO assigned to its channel.
// - Two list slots give double rate.
// - List ends at terminator entry.
// - List walked each frame from zero.
// - Mask acts only with nonzero count.
`timescale 1ns/1ns
`default_nettype none

module sbp_core #(
  parameter int unsigned N_FIFO = 32,
  parameter int unsigned N_CHAN = 32,
  parameter int unsigned N_LIST = 64
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire logic [7:0]            i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest,
  input  wire logic [N_FIFO*8-1:0]   i_fifo_data,
  output logic      [N_FIFO-1:0]     o_fifo_pop,
  output logic      [N_FIFO*8-1:0]   o_rx_data,
  output logic      [N_FIFO-1:0]     o_rx_push,
  input  wire logic [N_CHAN*8-1:0]   i_rx_chan,
  output logic      [N_CHAN*8-1:0]   o_tx_chan,
  output logic                       o_frame
);

  localparam int unsigned DIV_W = $clog2(sbp_pkg::FRAME_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST =
    DIV_W'(sbp_pkg::FRAME_CYCLES - 1);
  localparam int unsigned EW = sbp_pkg::ENTRY_W;
  localparam int unsigned CW = sbp_pkg::CHAN_W;
  localparam logic [EW-1:0] ENTRY_LAST = EW'(N_LIST - 1);
  localparam logic [EW-1:0] ENTRY_ONE  = EW'(1);

  // ****************************************************************
  // Configuration storage
  // ****************************************************************
  logic             mode_arb;
  logic             mode_list;
  logic [EW-1:0]    fifo_sel;
  logic [EW-1:0]    first_fifo;
  logic [2:0]       bit_count [N_LIST];
  logic [2:0]       start_bit [N_LIST];
  logic [CW-1:0]    chan_num  [N_LIST];
  logic [EW-1:0]    next_fifo [N_LIST];
  logic             list_term [N_LIST];
  logic [7:0]       fill_mask [N_CHAN];

  sbp_pkg::sbp_state_e state;
  logic [DIV_W-1:0] div_cnt;
  logic             frame_tick;
  logic [EW-1:0]    cursor;
  logic [EW-1:0]    cur_fifo;
  logic             phase;
  logic [15:0]      frame_cnt;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic         wr_go;
  logic         wr_lo;
  logic [7:0]   wd;
  logic [CW-1:0] sel_chan;

  assign wr_go = i_avs_write & ~o_avs_waitrequest;
  assign wr_lo = wr_go & i_avs_byteenable[0];
  assign wd    = i_avs_writedata[7:0];
  // Mask writes land on the channel of the selected FIFO or entry.
  assign sel_chan = (mode_arb | mode_list) ? chan_num[fifo_sel]
                                           : fifo_sel[EW-1:sbp_pkg::CHAN_LSB];

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_avs_waitrequest <= 1'b1;
    end else if (o_avs_waitrequest) begin
      o_avs_waitrequest <= ~(i_avs_read | i_avs_write);
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read & o_avs_waitrequest) begin
      case (i_avs_address)
        sbp_pkg::ADDR_MODE: begin
          o_avs_readdata <= {30'h0, mode_list, mode_arb};
        end
        sbp_pkg::ADDR_FIFO_SEL: begin
          o_avs_readdata <= {26'h0, fifo_sel};
        end
        sbp_pkg::ADDR_SUBCH_CFG: begin
          o_avs_readdata <= {26'h0, start_bit[fifo_sel],
                             bit_count[fifo_sel]};
        end
        sbp_pkg::ADDR_CHANNEL: begin
          o_avs_readdata <= {26'h0, chan_num[fifo_sel], 1'b0};
        end
        sbp_pkg::ADDR_FILL_MASK: begin
          o_avs_readdata <= {24'h0, fill_mask[sel_chan]};
        end
        sbp_pkg::ADDR_NEXT_FIFO: begin
          o_avs_readdata <= {25'h0, list_term[fifo_sel],
                             next_fifo[fifo_sel]};
        end
        sbp_pkg::ADDR_FIRST_FIFO: begin
          o_avs_readdata <= {26'h0, first_fifo};
        end
        sbp_pkg::ADDR_STATUS: begin
          o_avs_readdata <= {(state != sbp_pkg::SBP_IDLE), 15'h0,
                             frame_cnt};
        end
        default: begin
          o_avs_readdata <= 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_arb   <= 1'b0;
      mode_list  <= 1'b0;
      fifo_sel   <= '0;
      first_fifo <= '0;
    end else if (wr_lo) begin
      case (i_avs_address)
        sbp_pkg::ADDR_MODE: begin
          mode_arb  <= wd[sbp_pkg::MODE_ARB_BIT];
          mode_list <= wd[sbp_pkg::MODE_LIST_BIT];
        end
        sbp_pkg::ADDR_FIFO_SEL: begin
          fifo_sel <= wd[EW-1:0];
        end
        sbp_pkg::ADDR_FIRST_FIFO: begin
          first_fifo <= wd[EW-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Per FIFO (or per list entry) subchannel and assignment settings.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < N_LIST; i++) begin
        bit_count[i] <= sbp_pkg::RST_BIT_COUNT;
        start_bit[i] <= sbp_pkg::RST_START_BIT;
        chan_num[i]  <= '0;
        next_fifo[i] <= '0;
        list_term[i] <= 1'b0;
      end
    end else if (wr_lo) begin
      case (i_avs_address)
        sbp_pkg::ADDR_SUBCH_CFG: begin
          bit_count[fifo_sel] <=
            wd[sbp_pkg::CNT_LSB +: sbp_pkg::FIELD3_W];
          start_bit[fifo_sel] <= wd[sbp_pkg::START_LSB +: sbp_pkg::FIELD3_W];
        end
        sbp_pkg::ADDR_CHANNEL: begin
          chan_num[fifo_sel] <= wd[sbp_pkg::CHAN_LSB +: CW];
        end
        sbp_pkg::ADDR_NEXT_FIFO: begin
          next_fifo[fifo_sel] <= wd[EW-1:0];
          list_term[fifo_sel] <= wd[sbp_pkg::TERM_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Frame divider
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt    <= '0;
      frame_tick <= 1'b0;
    end else begin
      frame_tick <= (div_cnt == DIV_LAST);
      div_cnt    <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
    end
  end

  // ****************************************************************
  // Entry walk
  // ****************************************************************
  // In fixed and arbitrary mode the entry is {fifo, dir} itself; in
  // list mode it is taken from the chain of next-FIFO entries.
  logic [EW-1:0] ent;
  logic          ent_rx;
  logic [CW-1:0] ent_fifo;
  logic [CW-1:0] ent_chan;
  logic          last_ent;
  logic [7:0]    win;
  logic [7:0]    head;

  assign ent      = mode_list ? cur_fifo : cursor;
  assign ent_rx   = ent[0];
  assign ent_fifo = ent[EW-1:sbp_pkg::CHAN_LSB];
  assign ent_chan = (mode_arb | mode_list) ? chan_num[cursor]
                                           : ent_fifo;
  assign last_ent = (cursor == ENTRY_LAST) |
                    (mode_list & list_term[cursor]);
  assign head     = i_fifo_data[ent_fifo*8 +: 8];

  // Bits claimed by the entry; a zero count claims the whole byte.
  function automatic logic [7:0] claim(input logic [2:0] cnt,
                                       input logic [2:0] start);
    logic [15:0] ones;
    ones = (16'h1 << cnt) - 16'h1;
    ones = ones << start;
    claim = (cnt == 3'h0) ? 8'hFF : ones[7:0];
  endfunction

  assign win = claim(bit_count[cursor], start_bit[cursor]);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state     <= sbp_pkg::SBP_IDLE;
      cursor    <= '0;
      cur_fifo  <= '0;
      phase     <= 1'b0;
      frame_cnt <= 16'h0;
    end else begin
      case (state)
        sbp_pkg::SBP_IDLE: begin
          if (frame_tick) begin
            state    <= sbp_pkg::SBP_WALK;
            cursor   <= '0;
            cur_fifo <= first_fifo;
            phase    <= 1'b0;
          end
        end
        sbp_pkg::SBP_WALK: begin
          phase <= ~phase;
          // Two cycles per entry let a popped FIFO present its next byte.
          if (phase) begin
            if (last_ent) begin
              state <= sbp_pkg::SBP_LATCH;
            end else begin
              cursor   <= cursor + ENTRY_ONE;
              cur_fifo <= next_fifo[cursor];
            end
          end
        end
        sbp_pkg::SBP_LATCH: begin
          state     <= sbp_pkg::SBP_IDLE;
          frame_cnt <= frame_cnt + 16'h1;
        end
        default: begin
          state <= sbp_pkg::SBP_IDLE;
        end
      endcase
    end
  end

  logic do_entry;
  assign do_entry = (state == sbp_pkg::SBP_WALK) & ~phase;

  // ****************************************************************
  // Channel masks and transmit merge
  // ****************************************************************
  // The mask holds the merged bits, so it carries processed FIFO data
  // until software writes it again.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int c = 0; c < N_CHAN; c++) begin
        fill_mask[c] <= sbp_pkg::RST_MASK;
      end
    end else begin
      if (do_entry & ~ent_rx) begin
        fill_mask[ent_chan] <= (fill_mask[ent_chan] & ~win) |
                               (head & win);
      end
      if (wr_lo & (i_avs_address == sbp_pkg::ADDR_FILL_MASK)) begin
        fill_mask[sel_chan] <= wd;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tx_chan <= '0;
      o_frame   <= 1'b0;
    end else begin
      o_frame <= (state == sbp_pkg::SBP_LATCH);
      if (state == sbp_pkg::SBP_LATCH) begin
        for (int c = 0; c < N_CHAN; c++) begin
          o_tx_chan[c*8 +: 8] <= fill_mask[c];
        end
      end
    end
  end

  // ****************************************************************
  // FIFO strobes and receive insertion
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fifo_pop <= '0;
      o_rx_push  <= '0;
      o_rx_data  <= '0;
    end else begin
      o_fifo_pop <= '0;
      o_rx_push  <= '0;
      if (do_entry & ~ent_rx) begin
        o_fifo_pop[ent_fifo] <= 1'b1;
      end
      if (do_entry & ent_rx) begin
        o_rx_push[ent_fifo] <= 1'b1;
        // Receive ignores count, start and mask.
        o_rx_data[ent_fifo*8 +: 8] <=
          i_rx_chan[ent_chan*8 +: 8];
      end
    end
  end

endmodule

`default_nettype wire

/* verif/sbp_core_monitor.sv */
// Port checker for sbp_core, bound to every instance.
// Assumes the bus and frame timing of the hand-over contract.
`timescale 1ns/1ns
`default_nettype none
module sbp_core_monitor #(
  parameter int unsigned N_FIFO = 32,
  parameter int unsigned N_CHAN = 32
) (
  input wire logic                i_clk,
  input wire logic                i_nrst,
  input wire logic                i_avs_read,
  input wire logic                i_avs_write,
  input wire logic                o_avs_waitrequest,
  input wire logic [N_FIFO-1:0]   o_fifo_pop,
  input wire logic [N_FIFO-1:0]   o_rx_push,
  input wire logic [N_CHAN*8-1:0] o_tx_chan,
  input wire logic                o_frame
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  a_bus_answer: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest) else $error("late answer");
  a_bus_short: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("wait low too long");
  a_bus_idle: assert property (!i_avs_read && !i_avs_write |=>
    o_avs_waitrequest) else $error("answer without request");
  a_frame_gap: assert property (o_frame |=> !o_frame [*8])
    else $error("frame pulses too close");
  a_tx_frame: assert property (!o_frame |-> $stable(o_tx_chan))
    else $error("channel byte moved off frame");
  a_pop_single: assert property (|o_fifo_pop |->
    $onehot(o_fifo_pop) ##1 o_fifo_pop == '0) else $error("pop burst");
  a_push_single: assert property (|o_rx_push |->
    $onehot(o_rx_push) ##1 o_rx_push == '0) else $error("push burst");
  a_frame_quiet: assert property (o_frame |-> !(|o_fifo_pop) &&
    !(|o_rx_push)) else $error("transfer on frame pulse");
endmodule
bind sbp_core sbp_core_monitor #(.N_FIFO(N_FIFO), .N_CHAN(N_CHAN)) u_mon (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_fifo_pop(o_fifo_pop), .o_rx_push(o_rx_push), .o_tx_chan(o_tx_chan),
  .o_frame(o_frame));
`default_nettype wire

/* verif/sbp_fabric_model.sv */
// Far-side model: transmit FIFO head bytes and a pop count per frame.
// Assumes pops are one-cycle pulses from the packer.
`timescale 1ns/1ns
`default_nettype none
module sbp_fabric_model #(
  parameter int unsigned N = 32
) (
  input  wire logic           i_clk,
  input  wire logic           i_nrst,
  input  wire logic [N-1:0]   i_pop,
  input  wire logic           i_frame,
  output logic      [N*8-1:0] o_head,
  output logic      [7:0]     o_npop
);
  // Each pop shows the FIFO's next byte on the following cycle.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int f = 0; f < N; f++) o_head[f*8+:8] <= 8'(f * 19);
    end else begin
      for (int f = 0; f < N; f++)
        if (i_pop[f]) o_head[f*8+:8] <= o_head[f*8+:8] + 8'h5B;
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_npop <= 8'h00;
    end else begin
      o_npop <= (i_frame ? 8'h00 : o_npop) + 8'($countones(i_pop));
    end
  end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for sbp_core with a behavioural channel model.
// Assumes the fabric model supplies FIFO heads and counts pops.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  logic [7:0]   addr = 8'h00;
  logic         rd = 1'b0;
  logic         wr = 1'b0;
  logic [31:0]  wdata = 32'h0;
  logic [3:0]   be = 4'hF;
  logic [255:0] rxv = 256'h0;
  logic [31:0]  seed = 32'h7853;
  logic [31:0]  rdata;
  logic [31:0]  r;
  logic [7:0]   mm[32];
  logic [7:0]   hs[32];
  logic [2:0]   cnt[32];
  logic [2:0]   st[32];
  logic [4:0]   chn[32];
  bit           arb = 1'b0;
  bit           lst = 1'b0;
  int           num_errors = 0;
  int           comparisons = 0;
  int           nfr = 0;
  wire  [31:0]  rq;
  wire          wq;
  wire  [255:0] head;
  wire  [31:0]  pop;
  wire  [255:0] rxd;
  wire  [31:0]  push;
  wire  [255:0] tx;
  wire          fr;
  wire  [7:0]   npop;
  always #50 clk = ~clk;
  sbp_core dut (.i_clk(clk), .i_nrst(nrst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rq), .o_avs_waitrequest(wq),
    .i_fifo_data(head), .o_fifo_pop(pop), .o_rx_data(rxd),
    .o_rx_push(push), .i_rx_chan(rxv), .o_tx_chan(tx), .o_frame(fr));
  sbp_fabric_model u_fab (.i_clk(clk), .i_nrst(nrst), .i_pop(pop),
    .i_frame(fr), .o_head(head), .o_npop(npop));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] win(input logic [2:0] c, input logic [2:0] s);
    return (c == 3'h0) ? 8'hFF : 8'(((8'h01 << c) - 8'h01) << s);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 40);
    rdata = rq;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40) begin
      chk(n, 0);
      report_and_stop();
    end
  endtask
  task automatic cfgw(input logic [7:0] s, c, ch, m);
    bus(sbp_pkg::ADDR_FIFO_SEL, 1'b1, s);
    bus(sbp_pkg::ADDR_SUBCH_CFG, 1'b1, c);
    bus(sbp_pkg::ADDR_CHANNEL, 1'b1, ch);
    bus(sbp_pkg::ADDR_FILL_MASK, 1'b1, m);
  endtask
  task automatic next_frame(input int np);
    int n;
    logic [7:0] w;
    logic [4:0] c;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (fr !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      num_errors++;
      report_and_stop();
    end
    nfr++;
    if (np == 32) begin
      for (int f = 0; f < 32; f++) begin
        c = arb ? chn[f] : 5'(f);
        w = win(cnt[f], st[f]);
        mm[c] = (mm[c] & ~w) | (hs[f] & w);
      end
    end
    for (int k = 0; k < 32; k++) chk(tx[k*8+:8], mm[k]);
    chk(npop, np);
    for (int f = 0; f < 32; f++) hs[f] = head[f*8+:8];
    @(posedge clk);
    for (int k = 0; k < 8; k++) rxv[k*32+:32] <= rnd();
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Each receive push must carry the whole byte of its channel.
  always @(negedge clk) begin
    int c;
    for (int f = 0; f < 32; f++) begin
      c = lst ? 7 : arb ? int'(chn[f]) : f;
      if (push[f] === 1'b1) chk(rxd[f*8+:8], rxv[c*8+:8]);
    end
  end
  initial begin
    #(20 * 125000);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int f = 0; f < 32; f++) begin
      hs[f] = head[f*8+:8];
      mm[f] = 8'h00;
      cnt[f] = 3'h0;
      st[f] = 3'h0;
      chn[f] = 5'(f);
    end
    be <= 4'h0;
    bus(sbp_pkg::ADDR_FILL_MASK, 1'b1, 8'hFF);
    be <= 4'hF;
    for (int i = 0; i < 4; i++) begin
      bus(8'(i == 3 ? 32 : i * 8), 1'b0, 8'h00);
      chk(rdata, 32'h0);
    end
    next_frame(32);
    for (int f = 0; f < 32; f++) begin
      r = rnd();
      {st[f], cnt[f]} = r[5:0];
      mm[f] = r[15:8];
      cfgw(8'(f << 1), {2'h0, r[5:0]}, 8'(f << 1), r[15:8]);
    end
    repeat (2) next_frame(32);
    arb = 1'b1;
    bus(sbp_pkg::ADDR_MODE, 1'b1, 8'h01);
    for (int f = 0; f < 32; f++) begin
      r = rnd();
      {st[f], cnt[f]} = r[5:0];
      chn[f] = 5'(r[17:16]);
      mm[chn[f]] = r[15:8];
      cfgw(8'(f << 1), {2'h0, r[5:0]}, {2'h0, chn[f], 1'b0},
           r[15:8]);
      bus(sbp_pkg::ADDR_FIFO_SEL, 1'b1, 8'(f * 2 + 1));
      bus(sbp_pkg::ADDR_SUBCH_CFG, 1'b1, r[31:24]);
      bus(sbp_pkg::ADDR_CHANNEL, 1'b1, {2'h0, chn[f], 1'b0});
    end
    repeat (2) next_frame(32);
    lst = 1'b1;
    bus(sbp_pkg::ADDR_MODE, 1'b1, 8'h03);
    bus(sbp_pkg::ADDR_FIRST_FIFO, 1'b1, 8'h0A);
    for (int i = 0; i < 3; i++) begin
      cfgw(8'(i), 8'h00, i == 1 ? 8'h12 : 8'h0E, 8'h00);
      bus(sbp_pkg::ADDR_NEXT_FIFO, 1'b1, i == 2 ? 8'h40 : 8'(10 + i));
    end
    repeat (2) begin
      mm[7] = hs[5];
      mm[9] = hs[5] + 8'h5B;
      next_frame(2);
    end
    bus(sbp_pkg::ADDR_STATUS, 1'b0, 8'h00);
    chk(rdata, 32'(nfr));
    bus(sbp_pkg::ADDR_NEXT_FIFO, 1'b0, 8'h00);
    chk(rdata, 32'h40);
    bus(sbp_pkg::ADDR_FILL_MASK, 1'b0, 8'h00);
    chk(rdata, {24'h0, mm[7]});
    report_and_stop();
  end
endmodule
`default_nettype wire
